// File: logic/spio_regs.vh
// Register indices, reset values and bus codes of the shared parallel I/O port.
// Assumes includers use the byte address {index, 2'b00} on a 32-bit AHB-Lite bus.
`ifndef SPIO_REGS_VH
`define SPIO_REGS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SPIO_IDX_DIR_A    10'h2C0
`define SPIO_IDX_PIN_A    10'h2C2
`define SPIO_IDX_LAT_A    10'h2C4
`define SPIO_IDX_DIR_B    10'h2C6
`define SPIO_IDX_PIN_B    10'h2C8
`define SPIO_IDX_LAT_B    10'h2CB
`define SPIO_IDX_ANALOG   10'h2E0

// ----------------------------------------------------------------
// Implemented bits and reset values
// ----------------------------------------------------------------
`define SPIO_MASK_A       16'hF6C0
`define SPIO_MASK_B       16'hFFFF
`define SPIO_RST_LAT      16'h0000
`define SPIO_RST_ANALOG   16'h0000
`define SPIO_ZERO16       16'h0000

// ----------------------------------------------------------------
// Bus codes
// ----------------------------------------------------------------
`define SPIO_HTRANS_NSEQ  2'h2
`define SPIO_HRESP_OKAY   1'h0
`define SPIO_ZERO32       32'h0000_0000

`endif

// File: logic/spio_sync.v
// Two-flop synchroniser for a vector of pad levels.
// Assumes asynchronous inputs; the first stage feeds only the second.
`timescale 1ns/100ps

module spio_sync #(
	parameter W = 16
) (
	// Clock, reset, enable
	input  wire         hclk,
	input  wire         hresetn,
	input  wire         ce,
	// Data
	input  wire [W-1:0] d_async,
	output reg  [W-1:0] d_sync
);

	reg [W-1:0] stage1;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stage1 <= {W{1'b0}};
			d_sync <= {W{1'b0}};
		end else if (ce) begin
			stage1 <= d_async;
			d_sync <= stage1;
		end
	end

endmodule

// File: logic/spio_port.v
// Shared parallel I/O port, ports A and B, with AHB-Lite register access.
// Assumes pads are asynchronous; peripheral controls come from logic on hclk.
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/100ps
`include "spio_regs.vh"

module spio_port #(
	parameter [15:0] IMPL_MASK_A     = `SPIO_MASK_A,
	parameter [15:0] IMPL_MASK_B     = `SPIO_MASK_B,
	parameter [15:0] PERIPH_OUT_A    = 16'hFFFF,
	parameter [15:0] PERIPH_OUT_B    = 16'hFFFF
) (
	// Clock, reset, enable
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        ce,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg         hreadyout,
	output reg         hresp,
	output reg  [31:0] hrdata,
	// Peripheral side, per pin
	input  wire [15:0] periph_en_a,
	input  wire [15:0] periph_drive_a,
	input  wire [15:0] periph_out_a,
	input  wire [15:0] periph_en_b,
	input  wire [15:0] periph_drive_b,
	input  wire [15:0] periph_out_b,
	// Pads
	input  wire [15:0] pad_in_a,
	output reg  [15:0] pad_out_a,
	output reg  [15:0] pad_oe_n_a,
	input  wire [15:0] pad_in_b,
	output reg  [15:0] pad_out_b,
	output reg  [15:0] pad_oe_n_b,
	// Converter routing, port B
	output reg  [15:0] adc_connect_b
);

	// ----------------------------------------------------------------
	// Bus state machine states
	// ----------------------------------------------------------------
	localparam [3:0] ST_IDLE  = 4'h1;
	localparam [3:0] ST_WDATA = 4'h2;
	localparam [3:0] ST_RWAIT = 4'h4;
	localparam [3:0] ST_RDATA = 4'h8;

	localparam [11:0] A_DIR_A  = {`SPIO_IDX_DIR_A, 2'b00};
	localparam [11:0] A_PIN_A  = {`SPIO_IDX_PIN_A, 2'b00};
	localparam [11:0] A_LAT_A  = {`SPIO_IDX_LAT_A, 2'b00};
	localparam [11:0] A_DIR_B  = {`SPIO_IDX_DIR_B, 2'b00};
	localparam [11:0] A_PIN_B  = {`SPIO_IDX_PIN_B, 2'b00};
	localparam [11:0] A_LAT_B  = {`SPIO_IDX_LAT_B, 2'b00};
	localparam [11:0] A_ANALOG = {`SPIO_IDX_ANALOG, 2'b00};

	localparam [31:0] IMPL_ALL   = {IMPL_MASK_B, IMPL_MASK_A};
	localparam [31:0] PERIPH_ALL = {PERIPH_OUT_B, PERIPH_OUT_A};

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	reg  [3:0]  state;
	reg  [11:0] addr;
	reg  [15:0] direction_reg_a;
	reg  [15:0] direction_reg_b;
	reg  [15:0] output_latch_reg_a;
	reg  [15:0] output_latch_reg_b;
	reg  [15:0] analog_pin_config;

	wire [15:0] pins_a;
	wire [15:0] pins_b;
	wire [15:0] pin_state_reg_a;
	wire [15:0] pin_state_reg_b;
	wire        accept;
	wire [15:0] wdata;
	wire        wr_phase;
	wire        hit_dir_a;
	wire        hit_pin_a;
	wire        hit_lat_a;
	wire        hit_dir_b;
	wire        hit_pin_b;
	wire        hit_lat_b;
	wire        hit_analog;
	wire        wr_dir_a;
	wire        wr_lat_a;
	wire        wr_dir_b;
	wire        wr_lat_b;
	wire        wr_analog;

	reg  [15:0] rd_mux;
	wire [31:0] next_pad_out;
	wire [31:0] next_pad_oe_n;

	// ----------------------------------------------------------------
	// Pad input synchronisers
	// ----------------------------------------------------------------
	spio_sync #(
		.W       (32)
	) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.ce      (ce),
		.d_async ({pad_in_b, pad_in_a}),
		.d_sync  ({pins_b, pins_a})
	);

	// Peripheral-owned pins still read back; analog and absent bits read zero
	assign pin_state_reg_a = pins_a & IMPL_MASK_A;
	assign pin_state_reg_b = pins_b & IMPL_MASK_B & ~analog_pin_config;

	assign accept = hsel & hready & (htrans == `SPIO_HTRANS_NSEQ);
	assign wdata  = hwdata[15:0];

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	always @* begin
		if (addr == A_DIR_A) begin
			rd_mux = direction_reg_a;
		end else if (addr == A_PIN_A) begin
			rd_mux = pin_state_reg_a;
		end else if (addr == A_LAT_A) begin
			rd_mux = output_latch_reg_a;
		end else if (addr == A_DIR_B) begin
			rd_mux = direction_reg_b;
		end else if (addr == A_PIN_B) begin
			rd_mux = pin_state_reg_b;
		end else if (addr == A_LAT_B) begin
			rd_mux = output_latch_reg_b;
		end else if (addr == A_ANALOG) begin
			rd_mux = analog_pin_config;
		end else begin
			rd_mux = `SPIO_ZERO16;
		end
	end

	// ----------------------------------------------------------------
	// Address decode of the latched data-phase address
	// ----------------------------------------------------------------
	assign hit_dir_a  = (addr == A_DIR_A);
	assign hit_pin_a  = (addr == A_PIN_A);
	assign hit_lat_a  = (addr == A_LAT_A);
	assign hit_dir_b  = (addr == A_DIR_B);
	assign hit_pin_b  = (addr == A_PIN_B);
	assign hit_lat_b  = (addr == A_LAT_B);
	assign hit_analog = (addr == A_ANALOG);

	// Write strobes; pin-state writes land in the latch
	assign wr_phase  = (state == ST_WDATA);
	assign wr_dir_a  = wr_phase & hit_dir_a;
	assign wr_lat_a  = wr_phase & (hit_lat_a | hit_pin_a);
	assign wr_dir_b  = wr_phase & hit_dir_b;
	assign wr_lat_b  = wr_phase & (hit_lat_b | hit_pin_b);
	assign wr_analog = wr_phase & hit_analog;

	// ----------------------------------------------------------------
	// Bus slave: writes answer at once, reads insert one wait cycle
	// ----------------------------------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state     <= ST_IDLE;
			addr      <= 12'h000;
			hreadyout <= 1'b1;
		end else if (ce) begin
			case (state)
				ST_RWAIT: begin
					hreadyout <= 1'b1;
					state     <= ST_RDATA;
				end
				default: begin
					if (accept) begin
						addr <= haddr[11:0];
						if (hwrite) begin
							hreadyout <= 1'b1;
							state     <= ST_WDATA;
						end else begin
							hreadyout <= 1'b0;
							state     <= ST_RWAIT;
						end
					end else begin
						hreadyout <= 1'b1;
						state     <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Read data; stands until the next read completes
	// ----------------------------------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= `SPIO_ZERO32;
		end else if (ce) begin
			if (state == ST_RWAIT) begin
				hrdata <= {`SPIO_ZERO16, rd_mux};
			end
		end
	end

	// Response is always OKAY
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= `SPIO_HRESP_OKAY;
		end else if (ce) begin
			hresp <= `SPIO_HRESP_OKAY;
		end
	end

	// ----------------------------------------------------------------
	// Direction registers; reset makes inputs of the pins set in both SPIO_MASK_A/SPIO_MASK_B and IMPL_MASK_A/IMPL_MASK_B
	// ----------------------------------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			direction_reg_a <= `SPIO_MASK_A & IMPL_MASK_A;
			direction_reg_b <= `SPIO_MASK_B & IMPL_MASK_B;
		end else if (ce) begin
			if (wr_dir_a) begin
				direction_reg_a <= wdata & IMPL_MASK_A;
			end
			if (wr_dir_b) begin
				direction_reg_b <= wdata & IMPL_MASK_B;
			end
		end
	end

	// ----------------------------------------------------------------
	// Output latches, written through latch or pin-state address
	// ----------------------------------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			output_latch_reg_a <= `SPIO_RST_LAT;
			output_latch_reg_b <= `SPIO_RST_LAT;
		end else if (ce) begin
			if (wr_lat_a) begin
				output_latch_reg_a <= wdata & IMPL_MASK_A;
			end
			if (wr_lat_b) begin
				output_latch_reg_b <= wdata & IMPL_MASK_B;
			end
		end
	end

	// ----------------------------------------------------------------
	// Analog selection, port B
	// ----------------------------------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			analog_pin_config <= `SPIO_RST_ANALOG;
		end else if (ce) begin
			if (wr_analog) begin
				analog_pin_config <= wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Pad output muxes, one pair per pin
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < 32; i = i + 1) begin : g_pad
			wire dir_bit;
			wire lat_bit;
			wire per_own;
			wire per_dat;
			if (i < 16) begin : g_a
				assign dir_bit = direction_reg_a[i];
				assign lat_bit = output_latch_reg_a[i];
				assign per_own = periph_en_a[i] & periph_drive_a[i];
				assign per_dat = periph_out_a[i];
			end else begin : g_b
				assign dir_bit = direction_reg_b[i-16];
				assign lat_bit = output_latch_reg_b[i-16];
				assign per_own = periph_en_b[i-16] & periph_drive_b[i-16];
				assign per_dat = periph_out_b[i-16];
			end
			// Input-only sharing never takes the pad
			wire own = IMPL_ALL[i] & PERIPH_ALL[i] & per_own;
			// Port drives when direction is zero, analog or not
			wire port_drv = IMPL_ALL[i] & ~dir_bit;
			assign next_pad_out[i]  = own ? per_dat : (lat_bit & IMPL_ALL[i]);
			assign next_pad_oe_n[i] = own ? 1'b0 : ~port_drv;
		end
	endgenerate

	// ----------------------------------------------------------------
	// Port A pad registers
	// ----------------------------------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pad_out_a  <= `SPIO_ZERO16;
			pad_oe_n_a <= 16'hFFFF;
		end else if (ce) begin
			pad_out_a  <= next_pad_out[15:0];
			pad_oe_n_a <= next_pad_oe_n[15:0];
		end
	end

	// ----------------------------------------------------------------
	// Port B pad registers
	// ----------------------------------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pad_out_b  <= `SPIO_ZERO16;
			pad_oe_n_b <= 16'hFFFF;
		end else if (ce) begin
			pad_out_b  <= next_pad_out[31:16];
			pad_oe_n_b <= next_pad_oe_n[31:16];
		end
	end

	// ----------------------------------------------------------------
	// Converter routing, analog pins only
	// ----------------------------------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			adc_connect_b <= `SPIO_ZERO16;
		end else if (ce) begin
			adc_connect_b <= analog_pin_config & IMPL_MASK_B;
		end
	end

endmodule

// File: sim/spio_pads.sv
// Pad model for one 16-pin port: driven pins loop back, released pins follow an outside level.
// Assumes the outside level is changed by the bench and never floats.
`timescale 1ns/100ps

module spio_pads (
	// Port side
	input  wire [15:0] pad_out,
	input  wire [15:0] pad_oe_n,
	// Outside source
	input  wire [15:0] ext_level,
	output wire [15:0] pad_in
);
	assign pad_in = (pad_out & ~pad_oe_n) | (ext_level & pad_oe_n);
endmodule

// File: sim/spio_port_sva.sv
// Concurrent checks on the ports of the shared parallel I/O port.
// Assumes one AHB-Lite slave whose hreadyout is the bus hready.
`timescale 1ns/100ps
`include "spio_regs.vh"

module spio_sva_chk (
	// Clock, reset, enable
	input wire        hclk,
	input wire        hresetn,
	input wire        ce,
	// Bus
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire        hready,
	input wire        hreadyout,
	input wire        hresp,
	input wire [31:0] hrdata,
	// Peripheral and pads
	input wire [15:0] periph_en_b,
	input wire [15:0] periph_drive_b,
	input wire [15:0] periph_out_b,
	input wire [15:0] pad_out_b,
	input wire [15:0] pad_oe_n_b,
	input wire [15:0] pad_oe_n_a,
	input wire [15:0] adc_connect_b
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_take; ce && hsel && hready && htrans == 2'h2; endsequence
	sequence s_rd; s_take ##0 !hwrite; endsequence
	sequence s_rd_done; !hreadyout ##1 hreadyout; endsequence

	read_wait_a: assert property (s_rd |=> s_rd_done) else $error("read wait cycle wrong");
	write_nowait_a: assert property (s_take ##0 hwrite |=> hreadyout) else $error("write stalled");
	resp_okay_a: assert property (!hresp) else $error("error response");
	rdata_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata)) else $error("read data moved");
	reset_input_a: assert property (!$past(hresetn) |-> (pad_oe_n_a & pad_oe_n_b) == 16'hFFFF)
		else $error("pin driven after reset");
	own_enable_a: assert property (ce && hresetn |=> (pad_oe_n_b & $past(periph_en_b) & $past(periph_drive_b)) == 16'h0000)
		else $error("owned pin not driven");
	own_data_a: assert property (ce && hresetn |=> ((pad_out_b ^ $past(periph_out_b)) & $past(periph_en_b)
		& $past(periph_drive_b)) == 16'h0000) else $error("owned pin data wrong");
	unimpl_drive_a: assert property ((~pad_oe_n_a & ~`SPIO_MASK_A) == 16'h0000)
		else $error("unimplemented pin driven");
	pin_mask_a: assert property (s_rd ##0 haddr[11:2] == `SPIO_IDX_PIN_A |=> ##1
		(hrdata[15:0] & ~`SPIO_MASK_A) == 16'h0000) else $error("unimplemented bit read one");
	analog_zero_a: assert property (s_rd ##0 haddr[11:2] == `SPIO_IDX_PIN_B |=> ##1
		(hrdata[15:0] & adc_connect_b) == 16'h0000) else $error("analog pin read one");
endmodule

// File: sim/tb_top.sv
// Bench for the shared parallel I/O port: bus master, pad models, read checks.
// Assumes spio_regs.vh on the include path; reads are checked from a queue.
`timescale 1ns/100ps
`include "spio_regs.vh"

module tb_top;
	localparam [31:0] DIR_A = `SPIO_IDX_DIR_A * 4, PIN_A = `SPIO_IDX_PIN_A * 4, LAT_A = `SPIO_IDX_LAT_A * 4;
	localparam [31:0] DIR_B = `SPIO_IDX_DIR_B * 4, PIN_B = `SPIO_IDX_PIN_B * 4, LAT_B = `SPIO_IDX_LAT_B * 4;
	localparam [31:0] ANA = `SPIO_IDX_ANALOG * 4, NONE = 32'h0000_0B04;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rd_ph = 0, ce = 1;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 0, hwdata = 0;
	logic [15:0] periph_en_a = 0, periph_drive_a = 0, periph_out_a = 0, ext_a = 0, ext_b = 0;
	logic [15:0] periph_en_b = 0, periph_drive_b = 0, periph_out_b = 0, r, own, p;
	logic [15:0] exp_q[$];
	int          bad_count = 0, cmp_count = 0;
	wire         hreadyout, hresp;
	wire  [31:0] hrdata;
	wire  [15:0] pad_in_a, pad_out_a, pad_oe_n_a, pad_in_b, pad_out_b, pad_oe_n_b, adc_connect_b;

	always #5 hclk = ~hclk;

	spio_port u_dut (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .periph_en_a, .periph_drive_a, .periph_out_a,
		.periph_en_b, .periph_drive_b, .periph_out_b, .pad_in_a, .pad_out_a, .pad_oe_n_a, .pad_in_b,
		.pad_out_b, .pad_oe_n_b, .adc_connect_b);
	spio_pads u_pads_a (.pad_out(pad_out_a), .pad_oe_n(pad_oe_n_a), .ext_level(ext_a), .pad_in(pad_in_a));
	spio_pads u_pads_b (.pad_out(pad_out_b), .pad_oe_n(pad_oe_n_b), .ext_level(ext_b), .pad_in(pad_in_b));

	// ----------------------------------------------------------------
	// Bus tasks and checks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic xfer(input logic w, input logic [31:0] a, input logic [15:0] d);
		hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0; hwdata <= {16'h0000, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask
	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [31:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		xfer(1'b0, a, 16'h0000);
	endtask
	task automatic settle;
		repeat (4) @(posedge hclk);
	endtask
	task automatic wrap_up;
		if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	always @(posedge hclk) begin
		if (rd_ph && hreadyout)
			chk("hrdata", hrdata[15:0], exp_q.pop_front());
		if (hreadyout)
			rd_ph <= hsel && htrans == 2'h2 && !hwrite;
	end

	initial begin
		repeat (3000) @(posedge hclk);
		bad_count++;
		wrap_up;
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(90416));
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1; ext_a <= $urandom; ext_b <= $urandom; periph_en_a <= $urandom; periph_out_a <= $urandom;
		periph_drive_a <= ~`SPIO_MASK_A;
		@(posedge hclk);
		chk("pad_oe_n_a", pad_oe_n_a, 16'hFFFF);
		wr(NONE, 16'hFFFF);
		settle;
		rd(DIR_A, `SPIO_MASK_A);
		rd(DIR_B, 16'hFFFF);
		rd(LAT_A, 16'h0000);
		rd(ANA, 16'h0000);
		rd(NONE, 16'h0000);
		rd(PIN_A, ext_a & `SPIO_MASK_A);
		r = $urandom;
		wr(LAT_A, r);
		wr(DIR_A, 16'h0000);
		settle;
		chk("pad_oe_n_a", pad_oe_n_a, ~`SPIO_MASK_A);
		chk("pad_out_a", pad_out_a, r & `SPIO_MASK_A);
		rd(LAT_A, r & `SPIO_MASK_A);
		rd(PIN_A, r & `SPIO_MASK_A);
		r = $urandom;
		wr(PIN_B, r);
		rd(LAT_B, r);
		periph_en_b <= $urandom; periph_drive_b <= $urandom; periph_out_b <= $urandom;
		settle;
		own = periph_en_b & periph_drive_b;
		chk("pad_oe_n_b", pad_oe_n_b, ~own);
		chk("pad_out_b", pad_out_b & own, periph_out_b & own);
		ce <= 1'b0; periph_en_b <= ~periph_en_b;
		settle;
		chk("pad_oe_n_b", pad_oe_n_b, ~own);
		ce <= 1'b1; periph_en_b <= ~periph_en_b;
		settle;
		rd(PIN_B, (periph_out_b & own) | (ext_b & ~own));
		wr(DIR_B, 16'h0000);
		settle;
		p = (periph_out_b & own) | (r & ~own);
		chk("pad_out_b", pad_out_b, p);
		rd(PIN_B, p);
		wr(ANA, 16'h00FF);
		settle;
		chk("adc_connect_b", adc_connect_b, 16'h00FF);
		chk("pad_oe_n_b", pad_oe_n_b, 16'h0000);
		rd(PIN_B, p & 16'hFF00);
		wr(DIR_B, 16'hFFFF);
		settle;
		rd(PIN_B, ((periph_out_b & own) | (ext_b & ~own)) & 16'hFF00);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(LAT_B, 16'h0000);
		rd(DIR_A, `SPIO_MASK_A);
		repeat (3) @(posedge hclk);
		wrap_up;
	end
endmodule

bind spio_port spio_sva_chk u_chk (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
	.hresp, .hrdata, .periph_en_b, .periph_drive_b, .periph_out_b, .pad_out_b, .pad_oe_n_b, .pad_oe_n_a,
	.adc_connect_b);
